// [include/gpp_defs.svh]
// Constants for the port three and port four general-purpose I/O block
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_P3_WIDTH 3
`define GPP_P4_WIDTH 8
`define GPP_P3_DIR_RST 3'h7
`define GPP_P4_DIR_RST 8'hFF
`define GPP_P3_PU_RST 3'h0
`define GPP_P4_PU_RST 8'h00
`define GPP_P4_OD_RST 2'h0
`define GPP_P3_LAT_RST 3'h0
`define GPP_P4_LAT_RST 8'h00
`define GPP_P4_OD_LO 2
`define GPP_P4_OD_HI 3
`define GPP_P4_TOOL_A 0
`define GPP_P4_TOOL_B 1
`endif

// [include/gpp_pkg.sv]
// Types for the port three and port four general-purpose I/O block
`default_nettype none
package gpp_pkg;
  typedef enum logic [1:0] {
    GPP_TOOL_NONE,
    GPP_TOOL_ONE_LINE,
    GPP_TOOL_TWO_LINE
  } gpp_tool_mode_t;
  typedef logic [2:0] gpp_p3_t;
  typedef logic [7:0] gpp_p4_t;
endpackage : gpp_pkg
`default_nettype wire

// [verilog/gpp_pin_sync.sv]
// Two-stage pin input synchroniser, parameterised width
`default_nettype none
module gpp_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage_one <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      stage_one <= pin_in;
      pin_sync <= stage_one;
    end
  end
endmodule : gpp_pin_sync
`default_nettype wire

// [verilog/gpp_ports.sv]
// Port three and port four general-purpose I/O logic with shared functions
//
// Behaviour
// [R01] Port three: output latch per pin, per-pin direction bit.
// [R02] Port three input pins get pull-up when select bit set.
// [R03] Reset forces all port three pins to input.
// [R04] Port three pins feed interrupts, chip select, timers, stop output.
// [R05] Software keeps port three timer output bits at zero for plain I/O.
// [R06] Port four: output latch per pin, per-pin direction bit.
// [R07] Port four input pins get pull-up when select bit set.
// [R08] Port four pins 2 and 3 can be open-drain individually.
// [R09] Reset forces all port four pins to input.
// [R10] Port four pins feed interrupts, serial, tool lines, timers.
// [R11] Tool connected: no pull-up on port four pins 0 and 1.
// [R12] Tool connected: port four pin 0 belongs to tool, not port.
// [R13] One-line tool mode: port four pin 1 stays a port pin.
// [R14] Two-line tool mode: port four pin 1 is tool line b.
// [R15] Software keeps port four timer output bits at zero for plain I/O.
// [R16] Software picks the port for dual-port functions via select registers.
// [R17] Pull-up applies only while the pin is an input.
// [R18] Data read gives pin level for inputs, latch for outputs.
`include "gpp_defs.svh"
`default_nettype none
module gpp_ports (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Port three software registers
  input wire logic port_three_data_wr,
  input wire gpp_pkg::gpp_p3_t port_three_data_wdata,
  input wire logic port_three_direction_wr,
  input wire gpp_pkg::gpp_p3_t port_three_direction_wdata,
  input wire logic port_three_pullup_select_wr,
  input wire gpp_pkg::gpp_p3_t port_three_pullup_select_wdata,
  output gpp_pkg::gpp_p3_t port_three_data_rdata,
  output gpp_pkg::gpp_p3_t port_three_direction,
  output gpp_pkg::gpp_p3_t port_three_pullup_select,
  // Port four software registers
  input wire logic port_four_data_wr,
  input wire gpp_pkg::gpp_p4_t port_four_data_wdata,
  input wire logic port_four_direction_wr,
  input wire gpp_pkg::gpp_p4_t port_four_direction_wdata,
  input wire logic port_four_pullup_select_wr,
  input wire gpp_pkg::gpp_p4_t port_four_pullup_select_wdata,
  input wire logic port_four_open_drain_select_wr,
  input wire logic [1:0] port_four_open_drain_select_wdata,
  output gpp_pkg::gpp_p4_t port_four_data_rdata,
  output gpp_pkg::gpp_p4_t port_four_direction,
  output gpp_pkg::gpp_p4_t port_four_pullup_select,
  output logic [1:0] port_four_open_drain_select,
  // Debug tool state and tool line b drive from the debug unit
  input wire gpp_pkg::gpp_tool_mode_t tool_mode,
  input wire logic debug_tool_line_b_out,
  input wire logic debug_tool_line_b_oe,
  output logic debug_tool_line_a_in,
  output logic debug_tool_line_b_in,
  // Alternate output functions (already steered by the select registers)
  input wire gpp_pkg::gpp_p3_t p3_alt_out,
  input wire gpp_pkg::gpp_p3_t p3_alt_en,
  input wire gpp_pkg::gpp_p4_t p4_alt_out,
  input wire gpp_pkg::gpp_p4_t p4_alt_en,
  // Synchronised pin levels to interrupt, serial and timer inputs
  output gpp_pkg::gpp_p3_t p3_func_in,
  output gpp_pkg::gpp_p4_t p4_func_in,
  // Pads
  input wire gpp_pkg::gpp_p3_t p3_pin_in,
  output gpp_pkg::gpp_p3_t p3_pin_out,
  output gpp_pkg::gpp_p3_t p3_pin_oe,
  output gpp_pkg::gpp_p3_t p3_pullup_en,
  input wire gpp_pkg::gpp_p4_t p4_pin_in,
  output gpp_pkg::gpp_p4_t p4_pin_out,
  output gpp_pkg::gpp_p4_t p4_pin_oe,
  output gpp_pkg::gpp_p4_t p4_pullup_en
);
  import gpp_pkg::*;

  gpp_p3_t p3_latch;
  gpp_p4_t p4_latch;
  gpp_p3_t p3_sync;
  gpp_p4_t p4_sync;
  logic tool_on;
  logic two_line;
  gpp_p4_t tool_owned;
  gpp_p4_t pu_block;
  gpp_p4_t od_mask;
  gpp_p3_t p3_drive_val;
  gpp_p4_t p4_drive_val;
  gpp_p3_t next_p3_rd;
  logic [7:0] p3_rd_wide;
  gpp_p4_t next_p4_rd;

  // Read value: pin for inputs, latch for outputs
  function automatic logic [7:0] read_mux(input logic [7:0] dir,
                                          input logic [7:0] pin,
                                          input logic [7:0] lat);
    read_mux = (dir & pin) | (~dir & lat);
  endfunction : read_mux

  // Pin synchronisers for both ports
  gpp_pin_sync #(.WIDTH(`GPP_P3_WIDTH)) u_sync3 (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(p3_pin_in),
    .pin_sync(p3_sync)
  );
  gpp_pin_sync #(.WIDTH(`GPP_P4_WIDTH)) u_sync4 (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(p4_pin_in),
    .pin_sync(p4_sync)
  );

  // Port three registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      p3_latch <= `GPP_P3_LAT_RST;
      port_three_direction <= `GPP_P3_DIR_RST; // [R03]
      port_three_pullup_select <= `GPP_P3_PU_RST;
    end else if (clk_en) begin
      if (port_three_data_wr)
        p3_latch <= port_three_data_wdata; // [R01]
      if (port_three_direction_wr)
        port_three_direction <= port_three_direction_wdata; // [R01]
      if (port_three_pullup_select_wr)
        port_three_pullup_select <= port_three_pullup_select_wdata; // [R02]
    end
  end

  // Port four registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      p4_latch <= `GPP_P4_LAT_RST;
      port_four_direction <= `GPP_P4_DIR_RST; // [R09]
      port_four_pullup_select <= `GPP_P4_PU_RST;
      port_four_open_drain_select <= `GPP_P4_OD_RST;
    end else if (clk_en) begin
      if (port_four_data_wr)
        p4_latch <= port_four_data_wdata; // [R06]
      if (port_four_direction_wr)
        port_four_direction <= port_four_direction_wdata; // [R06]
      if (port_four_pullup_select_wr)
        port_four_pullup_select <= port_four_pullup_select_wdata; // [R07]
      if (port_four_open_drain_select_wr)
        port_four_open_drain_select <= port_four_open_drain_select_wdata;
    end
  end

  // Tool ownership of port four pins 0 and 1
  assign tool_on = (tool_mode != GPP_TOOL_NONE);
  assign two_line = (tool_mode == GPP_TOOL_TWO_LINE);
  assign tool_owned = {6'h00, two_line, tool_on}; // [R12] [R13] [R14]
  assign pu_block = {6'h00, tool_on, tool_on}; // [R11]
  assign od_mask = {4'h0, port_four_open_drain_select, 2'h0}; // [R08]

  // Drive values: alternate function overrides the latch when enabled
  assign p3_drive_val = (p3_alt_en & p3_alt_out) | (~p3_alt_en & p3_latch);
  assign p4_drive_val = (p4_alt_en & p4_alt_out) | (~p4_alt_en & p4_latch);

  // Port three pad control
  assign p3_pin_out = p3_drive_val;
  assign p3_pin_oe = ~port_three_direction | p3_alt_en; // [R01] [R04]
  assign p3_pullup_en = port_three_pullup_select
                        & port_three_direction; // [R02] [R17]

  // Port four pad control; open-drain pins drive only low
  assign p4_pin_out = tool_owned[`GPP_P4_TOOL_B] ?
                      {p4_drive_val[7:2], debug_tool_line_b_out, 1'b0}
                      : (p4_drive_val & ~tool_owned);
  assign p4_pin_oe = ((~port_four_direction | p4_alt_en) & ~tool_owned
                      & ~(od_mask & p4_drive_val))
                     | (tool_owned & {6'h00, debug_tool_line_b_oe, 1'b0})
                     ; // [R06] [R08] [R12] [R14]
  assign p4_pullup_en = port_four_pullup_select & port_four_direction
                        & ~pu_block & ~tool_owned; // [R07] [R11] [R17]

  // Shared inputs to interrupt, serial, timer and tool logic
  assign p3_func_in = p3_sync; // [R04]
  assign p4_func_in = p4_sync & ~tool_owned; // [R10]
  assign debug_tool_line_a_in = p4_sync[`GPP_P4_TOOL_A];
  assign debug_tool_line_b_in = p4_sync[`GPP_P4_TOOL_B];

  // Registered data reads
  assign p3_rd_wide = read_mux({5'h00, port_three_direction},
                               {5'h00, p3_sync},
                               {5'h00, p3_latch}); // [R18]
  assign next_p3_rd = p3_rd_wide[2:0];
  assign next_p4_rd = read_mux(port_four_direction, p4_sync, p4_latch)
                      & ~tool_owned; // [R18] [R12]

  always_ff @(posedge mclk) begin
    if (srst) begin
      port_three_data_rdata <= '0;
      port_four_data_rdata <= '0;
    end else if (clk_en) begin
      port_three_data_rdata <= next_p3_rd;
      port_four_data_rdata <= next_p4_rd;
    end
  end

  // Assertions
  property p_p3_reset_input;
    @(posedge mclk) srst |=> (port_three_direction == 3'h7);
  endproperty
  a_p3_reset_input: assert property (p_p3_reset_input) // [R03]
    else $error("port three not input after reset");

  property p_p4_reset_input;
    @(posedge mclk) srst |=> (port_four_direction == 8'hFF
      && (p4_pin_oe[7:2] & ~p4_alt_en[7:2]) == 6'h00);
  endproperty
  a_p4_reset_input: assert property (p_p4_reset_input) // [R09]
    else $error("port four not input after reset");

  property p_p3_latch_write;
    @(posedge mclk) disable iff (srst)
      (clk_en && port_three_data_wr && p3_alt_en == 3'h0)
      |=> (p3_pin_out == $past(port_three_data_wdata));
  endproperty
  a_p3_latch_write: assert property (p_p3_latch_write) // [R01]
    else $error("port three latch not driven");

  property p_p3_pullup_only_input;
    @(posedge mclk) disable iff (srst)
      (p3_pullup_en & ~port_three_direction) == 3'h0;
  endproperty
  a_p3_pullup_only_input: assert property (p_p3_pullup_only_input) // [R17]
    else $error("port three pull-up on output pin");

  property p_p4_pullup_select;
    @(posedge mclk) disable iff (srst)
      (clk_en && port_four_pullup_select_wr && !tool_on
       && port_four_direction == 8'hFF)
      |=> (p4_pullup_en == $past(port_four_pullup_select_wdata))
          || $changed(tool_mode) || $changed(port_four_direction);
  endproperty
  a_p4_pullup_select: assert property (p_p4_pullup_select) // [R07]
    else $error("port four pull-up does not follow select");

  property p_tool_no_pullup;
    @(posedge mclk) disable iff (srst)
      tool_on |-> (p4_pullup_en[1:0] == 2'h0);
  endproperty
  a_tool_no_pullup: assert property (p_tool_no_pullup) // [R11]
    else $error("pull-up on tool pins");

  property p_tool_a_owned;
    @(posedge mclk) disable iff (srst)
      tool_on |-> (!p4_pin_oe[0] && !p4_func_in[0]);
  endproperty
  a_tool_a_owned: assert property (p_tool_a_owned) // [R12]
    else $error("pin 0 used as port under tool");

  property p_one_line_port;
    @(posedge mclk) disable iff (srst)
      (tool_mode == GPP_TOOL_ONE_LINE && !port_four_direction[1]
       && !p4_alt_en[1]) |-> (p4_pin_oe[1] && p4_pin_out[1] == p4_latch[1]);
  endproperty
  a_one_line_port: assert property (p_one_line_port) // [R13]
    else $error("pin 1 not a port in one-line mode");

  property p_two_line_tool;
    @(posedge mclk) disable iff (srst)
      two_line |-> (p4_pin_oe[1] == debug_tool_line_b_oe);
  endproperty
  a_two_line_tool: assert property (p_two_line_tool) // [R14]
    else $error("pin 1 not tool line in two-line mode");

  property p_open_drain;
    @(posedge mclk) disable iff (srst)
      (port_four_open_drain_select[0] && p4_drive_val[2]) |-> !p4_pin_oe[2];
  endproperty
  a_open_drain: assert property (p_open_drain) // [R08]
    else $error("open-drain pin drives high");

  property p_read_input;
    @(posedge mclk) disable iff (srst)
      (clk_en && port_three_direction[0])
      |=> (port_three_data_rdata[0] == $past(p3_sync[0]));
  endproperty
  a_read_input: assert property (p_read_input) // [R18]
    else $error("port three read mismatch");

  c_tool_two: cover property (@(posedge mclk) two_line);
  c_od_low: cover property (@(posedge mclk) p4_pin_oe[3] && od_mask[3]);
  c_p3_out: cover property (@(posedge mclk) p3_pin_oe == 3'h7);
endmodule : gpp_ports
`default_nettype wire

// [verif/gpp_ports_test.sv]
// Self-checking bench for the port three and port four I/O block
`default_nettype none
module gpp_ports_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpp_pkg::*;
  logic mclk, srst, clk_en, w3d, w3m, w3p, w4d, w4m, w4p, w4o, bo, boe;
  logic ta, tb;
  logic [1:0] odw, od, mo;
  gpp_tool_mode_t tm;
  gpp_p3_t d3, m3, u3, a3o, a3e, pin3, rd3, dr3, pu3, f3, o3, oe3, pe3;
  gpp_p3_t ml3, mm3, mu3;
  gpp_p4_t d4, m4, u4, a4o, a4e, pin4, rd4, dr4, pu4, f4, o4, oe4, pe4;
  gpp_p4_t ml4, mm4, mu4;
  logic [31:0] rng;
  int error_cnt, checked;

  gpp_ports dut (.mclk(mclk), .srst(srst), .clk_en(clk_en),
    .port_three_data_wr(w3d), .port_three_data_wdata(d3),
    .port_three_direction_wr(w3m), .port_three_direction_wdata(m3),
    .port_three_pullup_select_wr(w3p), .port_three_pullup_select_wdata(u3),
    .port_three_data_rdata(rd3), .port_three_direction(dr3),
    .port_three_pullup_select(pu3), .port_four_data_wr(w4d),
    .port_four_data_wdata(d4), .port_four_direction_wr(w4m),
    .port_four_direction_wdata(m4), .port_four_pullup_select_wr(w4p),
    .port_four_pullup_select_wdata(u4), .port_four_open_drain_select_wr(w4o),
    .port_four_open_drain_select_wdata(odw), .port_four_data_rdata(rd4),
    .port_four_direction(dr4), .port_four_pullup_select(pu4),
    .port_four_open_drain_select(od), .tool_mode(tm),
    .debug_tool_line_b_out(bo), .debug_tool_line_b_oe(boe),
    .debug_tool_line_a_in(ta), .debug_tool_line_b_in(tb),
    .p3_alt_out(a3o), .p3_alt_en(a3e), .p4_alt_out(a4o), .p4_alt_en(a4e),
    .p3_func_in(f3), .p4_func_in(f4), .p3_pin_in(pin3), .p3_pin_out(o3),
    .p3_pin_oe(oe3), .p3_pullup_en(pe3), .p4_pin_in(pin4), .p4_pin_out(o4),
    .p4_pin_oe(oe4), .p4_pullup_en(pe4));

  // Free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Expected port four pad, read and function values
  function automatic void e4(output gpp_p4_t oe, out, pe, rd, fi);
    logic dv;
    gpp_p4_t own, blk;
    own = {6'h00, tm == GPP_TOOL_TWO_LINE, tm != GPP_TOOL_NONE};
    blk = {6'h00, tm != GPP_TOOL_NONE, tm != GPP_TOOL_NONE};
    for (int i = 0; i < 8; i++) begin
      dv = a4e[i] ? a4o[i] : ml4[i];
      out[i] = dv;
      oe[i] = a4e[i] | ~mm4[i];
      if ((i == 2 || i == 3) && mo[i-2] && dv) oe[i] = 1'b0;
    end
    if (tm != GPP_TOOL_NONE) oe[0] = 1'b0;
    if (tm == GPP_TOOL_TWO_LINE) begin
      oe[1] = boe;
      out[1] = bo;
    end
    pe = mu4 & mm4 & ~blk;
    rd = ((mm4 & pin4) | (~mm4 & ml4)) & ~own;
    fi = pin4 & ~own;
  endfunction : e4

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic chkall;
    gpp_p4_t oe, out, pe, rd, fi;
    e4(oe, out, pe, rd, fi);
    chk("dir3", dr3, mm3);
    chk("dir4", dr4, mm4);
    chk("pu3", pu3, mu3);
    chk("pu4", pu4, mu4);
    chk("od4", od, mo);
    chk("oe3", oe3, gpp_p3_t'(a3e | ~mm3));
    chk("out3", o3 & oe3, ((a3e & a3o) | (~a3e & ml3)) & oe3);
    chk("pe3", pe3 & ~a3e, mu3 & mm3 & ~a3e);
    chk("rd3", rd3, (mm3 & pin3) | (~mm3 & ml3));
    chk("fi3", f3, pin3);
    chk("oe4", oe4, oe);
    chk("out4", o4 & oe, out & oe);
    chk("pe4", pe4 & ~a4e, pe & ~a4e);
    chk("rd4", rd4, rd);
    chk("fi4", f4, fi);
    chk("tool", {ta, tb}, {pin4[0], pin4[1]});
  endtask : chkall

  // One write cycle to any mix of the seven registers, then a settle period and a full comparison
  task automatic step(input logic d, input logic [31:0] fa, fb, fc);
    logic [31:0] a, b, c;
    rng = xs(rng);
    a = d ? fa : rng;
    rng = xs(rng);
    b = d ? fb : rng;
    rng = xs(rng);
    c = d ? fc : rng;
    @(posedge mclk);
    clk_en <= |c[31:30];
    {w3d, w3m, w3p, w4d, w4m, w4p, w4o} <= a[6:0];
    d3 <= a[10:8];
    m3 <= a[13:11];
    u3 <= a[16:14];
    a3o <= a[19:17];
    a3e <= a[22:20] & {3{a[23]}};
    pin3 <= a[26:24];
    {pin4, u4, m4, d4} <= b;
    a4o <= c[7:0];
    a4e <= c[15:8] & c[23:16];
    odw <= c[25:24];
    bo <= c[26];
    boe <= c[27];
    tm <= gpp_tool_mode_t'(c[29:28] % 2'h3);
    if (|c[31:30]) begin
      if (a[6]) ml3 = a[10:8];
      if (a[5]) mm3 = a[13:11];
      if (a[4]) mu3 = a[16:14];
      if (a[3]) ml4 = b[7:0];
      if (a[2]) mm4 = b[15:8];
      if (a[1]) mu4 = b[23:16];
      if (a[0]) mo = c[25:24];
    end
    @(posedge mclk);
    {w3d, w3m, w3p, w4d, w4m, w4p, w4o} <= 7'h00;
    clk_en <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chkall;
  endtask : step

  // Synchronous reset, defaults checked while it is held
  task automatic rst(input int n);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    chk("rdir3", dr3, 8'h07);
    chk("rdir4", dr4, 8'hFF);
    chk("rpu3", pu3, 8'h00);
    chk("rpu4", pu4, 8'h00);
    chk("rpe3", pe3, 8'h00);
    chk("rpe4", pe4, 8'h00);
    chk("rod", od, 8'h00);
    chk("rrd3", rd3, 8'h00);
    chk("rrd4", rd4, 8'h00);
    srst <= 1'b0;
    {ml3, mu3, ml4, mu4, mo} = '0;
    mm3 = 3'h7;
    mm4 = 8'hFF;
  endtask : rst

  task complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence: reset, directed corners, random traffic with a second reset midway
  initial begin
    {srst, clk_en, w3d, w3m, w3p, w4d, w4m, w4p, w4o, bo, boe} = 11'h400;
    {d3, m3, u3, a3o, a3e, pin3, odw} = '0;
    {d4, m4, u4, a4o, a4e, pin4} = '0;
    tm = GPP_TOOL_NONE;
    rng = 32'h000024AF;
    error_cnt = 0;
    checked = 0;
    rst(12);
    step(1'b1, 32'h0001C77F, 32'h00FF00FF, 32'h83000000);
    step(1'b1, 32'h0501B87F, 32'hA5FFFF00, 32'hAC000000);
    step(1'b1, 32'h0501B87F, 32'h5AFFFF00, 32'h9C000000);
    for (int k = 0; k < 300; k++) begin
      step(1'b0, 0, 0, 0);
      if (k == 150) rst(2);
    end
    complete_run();
  end
endmodule : gpp_ports_test
`default_nettype wire
